// ---- design/tehc_buf.sv ----
// Byte buffer with registered read data for frames and payloads
`timescale 1ns/1ps
`default_nettype none
module tehc_buf #(
	parameter int AW = 8
) (
	input wire logic i_core_clk,
	tehc_mem_if.mem m
);
	logic [7:0] ram [0:(1<<AW)-1];
	logic [7:0] rdata_q;
	assign m.rdata = rdata_q;
	always_ff @(posedge i_core_clk) begin
		if (m.we) begin
			ram[m.waddr] <= m.wdata;
		end
		rdata_q <= ram[m.raddr];
	end
endmodule
`default_nettype wire

// ---- design/tehc_mem_if.sv ----
// Port bundle between the handler and its frame buffer
`timescale 1ns/1ps
`default_nettype none
interface tehc_mem_if #(parameter int AW = 8);
	logic we;
	logic [AW-1:0] waddr;
	logic [7:0] wdata;
	logic [AW-1:0] raddr;
	logic [7:0] rdata;
	modport ctl(output we, output waddr, output wdata, output raddr, input rdata);
	modport mem(input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// ---- design/tehc_pkg.sv ----
// Shared constants and types for the tag emulation command handler
package tehc_pkg;
	localparam int unsigned TEHC_AW = 8;
	// *****************************
	// Register byte addresses
	// *****************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CMD = 8'h04;
	localparam logic [7:0] ADDR_RESP = 8'h08;
	localparam logic [7:0] ADDR_STAT = 8'h0c;
	localparam logic [7:0] ADDR_CFG0 = 8'h10;
	localparam logic [7:0] ADDR_CFG1 = 8'h14;
	localparam int CTRL_PROT = 0;
	localparam int CTRL_TYPEA = 1;
	// *****************************
	// Command and answer codes
	// *****************************
	localparam logic [7:0] CMD_LISTEN = 8'h05;
	localparam logic [7:0] CMD_SEND = 8'h06;
	localparam logic [7:0] CMD_IDLE = 8'h07;
	localparam logic [7:0] CMD_ECHO = 8'h55;
	localparam logic [7:0] RC_OK = 8'h00;
	localparam logic [7:0] RC_FRAME = 8'h80;
	localparam logic [7:0] RC_LEN = 8'h82;
	localparam logic [7:0] RC_PROT = 8'h83;
	localparam logic [7:0] RC_CANCEL = 8'h85;
	localparam logic [7:0] RC_COMM = 8'h86;
	localparam logic [7:0] RC_SOF = 8'h88;
	localparam logic [7:0] RC_OVF = 8'h89;
	localparam logic [7:0] RC_FRAMING = 8'h8a;
	localparam logic [7:0] RC_EOF = 8'h8e;
	localparam logic [7:0] LEN_ZERO = 8'h00;
	localparam logic [7:0] LEN_IDLE = 8'h0e;
	localparam logic [7:0] LEN_WAKE = 8'h01;
	localparam logic [7:0] WAKE_FD = 8'h04;
	localparam logic [7:0] WAKE_PIN = 8'h08;
	// *****************************
	// Idle parameter byte positions
	// *****************************
	localparam logic [7:0] P_SRC = 8'h00;
	localparam logic [7:0] P_ENT = 8'h01;
	localparam logic [7:0] P_WAK = 8'h03;
	localparam logic [7:0] P_LEV = 8'h05;
	// *****************************
	// Receive status byte and errors
	// *****************************
	localparam int RXS_CRC = 5;
	localparam int RXS_PAR = 4;
	localparam logic [2:0] RXE_NONE = 3'h0;
	localparam logic [2:0] RXE_COMM = 3'h1;
	localparam logic [2:0] RXE_SOF = 3'h2;
	localparam logic [2:0] RXE_FRAMING = 3'h3;
	localparam logic [2:0] RXE_EOF = 3'h4;
	localparam logic [1:0] HDR_ONE = 2'h1;
	localparam logic [1:0] HDR_TWO = 2'h2;
	localparam logic [1:0] HDR_THREE = 2'h3;
	localparam logic [1:0] APB_LATCH = 2'h1;
	localparam logic [1:0] APB_DONE = 2'h2;
	typedef enum logic [2:0] {S_READY, S_LEN, S_PAYLOAD, S_LISTEN, S_SEND, S_WFE, S_RESP} tehc_state_t;
endpackage

// ---- design/tehc_top.sv ----
// Command handler for the card emulation side, with APB slave
// ******************************************
// Notes on behaviour
// - Good reader frame answers 80, length, data
// - Type A frames end with status byte
// - Check and CRC bytes stored before status
// - Listening cancel answers 55, 85, then zero length
// - Buffer overflow answers 89, zero length
// - Framing violation answers 8A, zero length
// - Errors 86, 88, 8E with zero length
// - Command 06 sends bytes, one per rising link clock edge
// - No protocol rejects send with 83
// - Successful send answers 00 00
// - Bad send length answers 82 00
// - Command 07 enters wait-for-event state
// - Wake answer 00 01 source, only on exit
// - Wake data carries the fired wake flags
// - Echo while listening answers 55 85 00
// ******************************************
`timescale 1ns/1ps
`default_nettype none
module tehc_top
	import tehc_pkg::*;
#(
	parameter logic [7:0] RX_LIMIT = 8'hfe
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_byte,
	input wire logic i_rx_end,
	input wire logic [2:0] i_rx_err,
	input wire logic i_rx_crc_err,
	input wire logic i_rx_par_err,
	input wire logic [3:0] i_rx_last_bits,
	input wire logic i_lm_clk,
	output logic [7:0] o_lm_byte,
	output logic o_lm_stb,
	output logic o_lm_last,
	output logic [7:0] o_lm_param,
	input wire logic i_field_det,
	input wire logic i_wake_b,
	output logic o_wait_for_event_state,
	output logic o_listening,
	output logic o_resp_ready,
	output logic [15:0] o_entry_resource_control,
	output logic [15:0] o_wake_resource_control,
	output logic [15:0] o_exit_resource_control,
	output logic [7:0] o_wake_source_select
);
	// ******************************************
	// State record
	// ******************************************
	typedef struct packed {
		tehc_state_t st;
		logic [7:0] cmd;
		logic [7:0] len;
		logic [7:0] cnt;
		logic [2:0][7:0] hdr;
		logic [1:0] hdr_n;
		logic [7:0] data_n;
		logic [7:0] rd_idx;
		logic listen_next;
		logic prot_ok;
		logic type_a;
		logic ovf;
		logic [7:0] src;
		logic [15:0] entry;
		logic [15:0] wakec;
		logic [15:0] leave;
		logic [7:0] wake_flag;
		logic [2:0] lm_s;
		logic [2:0] fd_s;
		logic [2:0] pin_s;
		logic [1:0] ph;
		logic [31:0] prdata;
		logic [7:0] tx_byte;
		logic tx_stb;
		logic tx_last;
		logic tx_pend;
		logic [7:0] param;
	} tehc_regs_t;

	tehc_regs_t q;
	tehc_regs_t d;
	tehc_mem_if #(.AW(TEHC_AW)) mif();

	tehc_buf #(.AW(TEHC_AW)) u_buf (
		.i_core_clk(i_core_clk),
		.m(mif.mem)
	);

	// ******************************************
	// Helpers
	// ******************************************
	function automatic tehc_regs_t respond(input tehc_regs_t s, input logic [7:0] h0, input logic [7:0] h1,
		input logic [7:0] h2, input logic [1:0] n, input logic [7:0] dn);
		tehc_regs_t r;
		r = s;
		r.hdr[0] = h0;
		r.hdr[1] = h1;
		r.hdr[2] = h2;
		r.hdr_n = n;
		r.data_n = dn;
		r.rd_idx = 8'h00;
		r.st = S_RESP;
		return r;
	endfunction

	function automatic logic [7:0] rx_err_code(input logic [2:0] e);
		logic [7:0] c;
		c = RC_COMM;
		if (e == RXE_SOF) begin
			c = RC_SOF;
		end else if (e == RXE_FRAMING) begin
			c = RC_FRAMING;
		end else if (e == RXE_EOF) begin
			c = RC_EOF;
		end
		return c;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return (a == ADDR_CTRL) || (a == ADDR_CMD) || (a == ADDR_RESP) || (a == ADDR_STAT) ||
			(a == ADDR_CFG0) || (a == ADDR_CFG1);
	endfunction

	logic acc;
	logic fire;
	logic cmd_ok;
	logic fin;
	logic lm_edge;
	logic fd_rise;
	logic pin_fall;
	logic [7:0] b;
	logic [7:0] wflag;
	logic [7:0] resp_byte;
	logic [31:0] rmux;
	logic [7:0] total;

	// ******************************************
	// Next state
	// ******************************************
	always_comb begin
		d = q;
		d.tx_stb = 1'b0;
		mif.we = 1'b0;
		mif.waddr = q.cnt;
		mif.wdata = i_rx_byte;
		fin = 1'b0;
		b = i_pwdata[7:0];
		wflag = 8'h00;
		// Two-flop synchronisers, third flop for edges
		d.lm_s = {q.lm_s[1:0], i_lm_clk};
		d.fd_s = {q.fd_s[1:0], i_field_det};
		d.pin_s = {q.pin_s[1:0], i_wake_b};
		lm_edge = q.lm_s[1] & ~q.lm_s[2];
		fd_rise = q.fd_s[1] & ~q.fd_s[2];
		pin_fall = ~q.pin_s[1] & q.pin_s[2];
		total = 8'({6'h00, q.hdr_n} + q.data_n);
		if (q.st == S_SEND) begin
			mif.raddr = q.rd_idx;
		end else begin
			mif.raddr = 8'(q.rd_idx - {6'h00, q.hdr_n});
		end
		if (q.rd_idx < {6'h00, q.hdr_n}) begin
			resp_byte = q.hdr[q.rd_idx[1:0]];
		end else begin
			resp_byte = mif.rdata;
		end

		// Engines of the waiting states
		case (q.st)
			S_LISTEN: begin
				if (i_rx_valid) begin
					if (q.cnt == RX_LIMIT) begin
						d.ovf = 1'b1;
					end else begin
						mif.we = 1'b1;
						d.cnt = 8'(q.cnt + 8'h01);
					end
				end else if (i_rx_end) begin
					if (i_rx_err != RXE_NONE) begin
						d = respond(q, rx_err_code(i_rx_err), LEN_ZERO, 8'h00, HDR_TWO, 8'h00);
					end else if (q.ovf) begin
						d = respond(q, RC_OVF, LEN_ZERO, 8'h00, HDR_TWO, 8'h00);
					end else if (q.type_a) begin
						mif.we = 1'b1;
						mif.wdata = {2'b00, i_rx_crc_err, i_rx_par_err, i_rx_last_bits};
						d = respond(q, RC_FRAME, 8'(q.cnt + 8'h01), 8'h00, HDR_TWO, 8'(q.cnt + 8'h01));
					end else begin
						d = respond(q, RC_FRAME, q.cnt, 8'h00, HDR_TWO, q.cnt);
					end
				end
			end
			S_SEND: begin
				if (q.tx_pend) begin
					d.tx_byte = mif.rdata;
					d.tx_stb = 1'b1;
					d.tx_last = (8'(q.rd_idx + 8'h01) == q.data_n);
					d.rd_idx = 8'(q.rd_idx + 8'h01);
					d.tx_pend = 1'b0;
				end else if (lm_edge) begin
					if (q.rd_idx == q.data_n) begin
						d = respond(q, RC_OK, LEN_ZERO, 8'h00, HDR_TWO, 8'h00);
					end else begin
						d.tx_pend = 1'b1;
					end
				end
			end
			S_WFE: begin
				if (fd_rise) begin
					wflag = wflag | (q.src & WAKE_FD);
				end
				if (pin_fall) begin
					wflag = wflag | (q.src & WAKE_PIN);
				end
				if (wflag != 8'h00) begin
					d.wake_flag = wflag;
					d = respond(d, RC_OK, LEN_WAKE, wflag, HDR_THREE, 8'h00);
				end
			end
			default: begin
			end
		endcase

		// APB slave, three access cycles per transfer
		acc = i_psel & i_penable;
		fire = acc && (q.ph == APB_DONE);
		if (!acc || fire) begin
			d.ph = 2'h0;
		end else begin
			d.ph = 2'(q.ph + 2'h1);
		end
		cmd_ok = (q.st == S_READY) || (q.st == S_LEN) || (q.st == S_PAYLOAD) || (q.st == S_LISTEN);
		if (i_paddr == ADDR_CTRL) begin
			rmux = {30'h0, q.type_a, q.prot_ok};
		end else if (i_paddr == ADDR_RESP) begin
			rmux = (q.st == S_RESP) ? {24'h0, resp_byte} : 32'h0;
		end else if (i_paddr == ADDR_STAT) begin
			rmux = {16'h0, q.wake_flag, 4'h0, q.st == S_SEND, q.st == S_WFE, q.st == S_LISTEN, q.st == S_RESP};
		end else if (i_paddr == ADDR_CFG0) begin
			rmux = {q.wakec, q.entry};
		end else if (i_paddr == ADDR_CFG1) begin
			rmux = {q.leave, 8'h00, q.src};
		end else begin
			rmux = 32'h0;
		end
		if (acc && (q.ph == APB_LATCH)) begin
			d.prdata = rmux;
		end
		o_pready = fire;
		o_pslverr = fire && (!mapped(i_paddr) || (i_pwrite && (i_paddr == ADDR_CMD) && !cmd_ok));

		if (fire && i_pwrite && (i_paddr == ADDR_CTRL)) begin
			d.prot_ok = i_pwdata[CTRL_PROT];
			d.type_a = i_pwdata[CTRL_TYPEA];
		end
		if (fire && !i_pwrite && (i_paddr == ADDR_RESP) && (q.st == S_RESP)) begin
			d.rd_idx = 8'(q.rd_idx + 8'h01);
			if (8'(q.rd_idx + 8'h01) == total) begin
				d.st = q.listen_next ? S_LISTEN : S_READY;
				d.listen_next = 1'b0;
				d.cnt = 8'h00;
				d.ovf = 1'b0;
			end
		end
		if (fire && i_pwrite && (i_paddr == ADDR_CMD) && cmd_ok) begin
			case (q.st)
				S_READY: begin
					d.cmd = b;
					if (b == CMD_ECHO) begin
						d = respond(d, CMD_ECHO, 8'h00, 8'h00, HDR_ONE, 8'h00);
					end else begin
						d.st = S_LEN;
					end
				end
				S_LEN: begin
					d.len = b;
					d.cnt = 8'h00;
					if (b == LEN_ZERO) begin
						fin = 1'b1;
					end else begin
						d.st = S_PAYLOAD;
					end
				end
				S_PAYLOAD: begin
					mif.we = 1'b1;
					mif.wdata = b;
					d.cnt = 8'(q.cnt + 8'h01);
					d.param = b;
					case (q.cnt)
						P_SRC: d.src = b;
						P_ENT: d.entry[15:8] = b;
						8'(P_ENT + 8'h01): d.entry[7:0] = b;
						P_WAK: d.wakec[15:8] = b;
						8'(P_WAK + 8'h01): d.wakec[7:0] = b;
						P_LEV: d.leave[15:8] = b;
						8'(P_LEV + 8'h01): d.leave[7:0] = b;
						default: begin
						end
					endcase
					if (8'(q.cnt + 8'h01) == q.len) begin
						fin = 1'b1;
					end
				end
				S_LISTEN: begin
					if (b == CMD_ECHO) begin
						d = respond(d, CMD_ECHO, RC_CANCEL, LEN_ZERO, HDR_THREE, 8'h00);
					end
				end
				default: begin
				end
			endcase
		end

		// Completed command with all its bytes
		if (fin) begin
			if (q.cmd == CMD_SEND) begin
				if (d.len == LEN_ZERO || (q.type_a && d.len == LEN_WAKE)) begin
					d = respond(d, RC_LEN, LEN_ZERO, 8'h00, HDR_TWO, 8'h00);
				end else if (!q.prot_ok) begin
					d = respond(d, RC_PROT, LEN_ZERO, 8'h00, HDR_TWO, 8'h00);
				end else begin
					d.st = S_SEND;
					d.rd_idx = 8'h00;
					d.tx_pend = 1'b0;
					d.data_n = q.type_a ? 8'(d.len - 8'h01) : d.len;
				end
			end else if (q.cmd == CMD_IDLE) begin
				if (d.len != LEN_IDLE) begin
					d = respond(d, RC_LEN, LEN_ZERO, 8'h00, HDR_TWO, 8'h00);
				end else begin
					d.st = S_WFE;
				end
			end else if (q.cmd == CMD_LISTEN) begin
				if (d.len != LEN_ZERO) begin
					d = respond(d, RC_LEN, LEN_ZERO, 8'h00, HDR_TWO, 8'h00);
				end else if (!q.prot_ok) begin
					d = respond(d, RC_PROT, LEN_ZERO, 8'h00, HDR_TWO, 8'h00);
				end else begin
					d = respond(d, RC_OK, LEN_ZERO, 8'h00, HDR_TWO, 8'h00);
					d.listen_next = 1'b1;
				end
			end else begin
				d = respond(d, RC_LEN, LEN_ZERO, 8'h00, HDR_TWO, 8'h00);
			end
		end
	end

	// ******************************************
	// State register
	// ******************************************
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			q <= '0;
			q.st <= S_READY;
			q.lm_s <= 3'h0;
			q.fd_s <= 3'h0;
			q.pin_s <= 3'h7;
		end else begin
			q <= d;
		end
	end

	// ******************************************
	// Outputs
	// ******************************************
	assign o_prdata = q.prdata;
	assign o_lm_byte = q.tx_byte;
	assign o_lm_stb = q.tx_stb;
	assign o_lm_last = q.tx_last;
	assign o_lm_param = q.param;
	assign o_wait_for_event_state = (q.st == S_WFE);
	assign o_listening = (q.st == S_LISTEN);
	assign o_resp_ready = (q.st == S_RESP);
	assign o_entry_resource_control = q.entry;
	assign o_wake_resource_control = q.wakec;
	assign o_exit_resource_control = q.leave;
	assign o_wake_source_select = q.src;
endmodule
`default_nettype wire

// ---- testbench/tehc_chk.sv ----
// Concurrent checks on the handler top ports
`timescale 1ns/1ps
`default_nettype none
module tehc_chk
	import tehc_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic o_lm_stb,
	input wire logic o_lm_last,
	input wire logic o_wait_for_event_state,
	input wire logic o_listening,
	input wire logic o_resp_ready
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_b);
	// ****
	// Bus and answer checks
	// ****
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	sequence s_answer;
		!o_pready ##1 !o_pready ##1 o_pready;
	endsequence
	property p_apb_wait; s_setup |=> s_answer; endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("pready off its cycle");
	property p_slverr; o_pslverr |-> o_pready && i_psel && i_penable; endproperty
	a_slverr: assert property (p_slverr) else $error("stray pslverr");
	property p_resp_hold;
		o_resp_ready && !(i_psel && i_penable && o_pready && !i_pwrite && i_paddr == ADDR_RESP) |=> o_resp_ready;
	endproperty
	a_resp_hold: assert property (p_resp_hold) else $error("answer lost unread");
	property p_listen_exit; $fell(o_listening) |-> ##[0:2] o_resp_ready; endproperty
	a_listen_exit: assert property (p_listen_exit) else $error("listen exit without answer");
	property p_wfe_silent; o_wait_for_event_state |-> !o_resp_ready; endproperty
	a_wfe_silent: assert property (p_wfe_silent) else $error("answer while waiting");
	property p_wfe_exit; $fell(o_wait_for_event_state) |-> ##[0:2] o_resp_ready; endproperty
	a_wfe_exit: assert property (p_wfe_exit) else $error("wake without answer");
	property p_wfe_quiet; o_wait_for_event_state |-> !o_listening && !o_lm_stb; endproperty
	a_wfe_quiet: assert property (p_wfe_quiet) else $error("activity while waiting");
	property p_stb_pulse; o_lm_stb |=> !o_lm_stb; endproperty
	a_stb_pulse: assert property (p_stb_pulse) else $error("strobe too long");
	property p_last_stb; $rose(o_lm_last) |-> o_lm_stb; endproperty
	a_last_stb: assert property (p_last_stb) else $error("last without strobe");
endmodule
bind tehc_top tehc_chk tehc_chk_inst (.i_core_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr, .o_pready,
	.o_pslverr, .o_lm_stb, .o_lm_last, .o_wait_for_event_state, .o_listening, .o_resp_ready);
`default_nettype wire

// ---- testbench/tehc_reader.sv ----
// Reader model: sends frames, paces and collects modulated bytes
`timescale 1ns/1ps
`default_nettype none
module tehc_reader (
	input wire logic i_core_clk,
	input wire logic i_run,
	input wire logic [7:0] i_lm_byte,
	input wire logic i_lm_stb,
	input wire logic i_lm_last,
	output logic o_rx_valid,
	output logic [7:0] o_rx_byte,
	output logic o_rx_end,
	output logic [2:0] o_rx_err,
	output logic o_rx_crc,
	output logic o_rx_par,
	output logic [3:0] o_rx_bits,
	output logic o_lm_clk
);
	logic [8:0] got[$];
	initial begin
		{o_rx_valid, o_rx_byte, o_rx_end, o_rx_err, o_rx_crc, o_rx_par, o_rx_bits} = '0;
	end
	// ****
	// Link clock, still outside sends
	// ****
	initial begin
		o_lm_clk = 1'b0;
		#3;
		forever begin
			#62.5;
			o_lm_clk = i_run ? ~o_lm_clk : 1'b0;
		end
	end
	always @(posedge i_core_clk) begin
		if (i_lm_stb) begin
			got.push_back({i_lm_last, i_lm_byte});
		end
	end
	// Payload bytes, then end with status
	task automatic frame(input int n, input logic [2:0] e, input logic c, input logic p);
		for (int i = 0; i < n; i++) begin
			@(posedge i_core_clk);
			o_rx_valid <= 1'b1;
			o_rx_byte <= 8'ha0 + 8'(i);
			@(posedge i_core_clk);
			o_rx_valid <= 1'b0;
			o_rx_byte <= ~(8'ha0 + 8'(i));
		end
		@(posedge i_core_clk);
		o_rx_end <= 1'b1;
		{o_rx_err, o_rx_crc, o_rx_par, o_rx_bits} <= {e, c, p, 4'h7};
		@(posedge i_core_clk);
		o_rx_end <= 1'b0;
		{o_rx_err, o_rx_crc, o_rx_par, o_rx_bits} <= ~{e, c, p, 4'h7};
	endtask
endmodule
`default_nettype wire

// ---- testbench/test_tag_emulation_command_handler.sv ----
// Self-checking bench for the tag emulation command handler
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; $display("FAIL %0t %h %h", $time, g, e); end end
module test_tag_emulation_command_handler import tehc_pkg::*;;
	logic i_core_clk, i_rst_b, i_psel, i_penable, i_pwrite, i_rx_valid, i_rx_end, i_rx_crc_err, i_rx_par_err;
	logic i_lm_clk, o_pready, o_pslverr, o_lm_stb, o_lm_last, i_field_det, i_wake_b, o_wait_for_event_state;
	logic o_listening, o_resp_ready, run, erv;
	logic [7:0] i_paddr, i_rx_byte, o_lm_byte, o_lm_param, o_wake_source_select;
	logic [31:0] i_pwdata, o_prdata, rdv;
	logic [2:0] i_rx_err;
	logic [3:0] i_rx_last_bits;
	logic [15:0] o_entry_resource_control, o_wake_resource_control, o_exit_resource_control;
	int bad_count, n_checks;
	tehc_top #(.RX_LIMIT(8'h04)) tehc_top_inst (.i_core_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr,
		.i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_rx_valid, .i_rx_byte, .i_rx_end, .i_rx_err, .i_rx_crc_err,
		.i_rx_par_err, .i_rx_last_bits, .i_lm_clk, .o_lm_byte, .o_lm_stb, .o_lm_last, .o_lm_param, .i_field_det,
		.i_wake_b, .o_wait_for_event_state, .o_listening, .o_resp_ready, .o_entry_resource_control,
		.o_wake_resource_control, .o_exit_resource_control, .o_wake_source_select);
	tehc_reader tehc_reader_inst (.i_core_clk, .i_run(run), .i_lm_byte(o_lm_byte), .i_lm_stb(o_lm_stb),
		.i_lm_last(o_lm_last), .o_rx_valid(i_rx_valid), .o_rx_byte(i_rx_byte), .o_rx_end(i_rx_end),
		.o_rx_err(i_rx_err), .o_rx_crc(i_rx_crc_err), .o_rx_par(i_rx_par_err), .o_rx_bits(i_rx_last_bits),
		.o_lm_clk(i_lm_clk));
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	// ****
	// Bus and command helpers
	// ****
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_core_clk);
		i_penable <= 1'b1;
		do @(posedge i_core_clk); while (o_pready !== 1'b1);
		rdv = o_prdata;
		erv = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_core_clk);
	endtask
	task automatic cmds(input logic [7:0] q[$]);
		foreach (q[i]) apb(1'b1, ADDR_CMD, {24'h0, q[i]});
	endtask
	task automatic resp(input logic [7:0] q[$]);
		for (int i = 0; i < 3000 && o_resp_ready !== 1'b1; i++) @(posedge i_core_clk);
		if (o_resp_ready !== 1'b1) begin
			bad_count++;
			report_and_stop();
		end
		foreach (q[i]) begin
			apb(1'b0, ADDR_RESP, 32'h0);
			`CHK(rdv[7:0], q[i])
		end
		`CHK(o_resp_ready, 1'b0)
	endtask
	task automatic listen();
		cmds('{CMD_LISTEN, LEN_ZERO});
		resp('{RC_OK, LEN_ZERO});
		`CHK(o_listening, 1'b1)
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_regs();
		apb(1'b0, ADDR_CTRL, 32'h0);
		`CHK(rdv, 32'h0)
		apb(1'b1, ADDR_CTRL, 32'h3);
		apb(1'b0, ADDR_CTRL, 32'h0);
		`CHK(rdv, 32'h3)
		apb(1'b0, 8'h20, 32'h0);
		`CHK({erv, rdv}, 33'h100000000)
	endtask
	task automatic t_frame(input logic c, input logic p);
		listen();
		tehc_reader_inst.frame(3, RXE_NONE, c, p);
		resp('{RC_FRAME, 8'h04, 8'ha0, 8'ha1, 8'ha2, {2'b00, c, p, 4'h7}});
	endtask
	task automatic t_errs();
		logic [7:0] rc[4];
		rc = '{RC_COMM, RC_SOF, RC_FRAMING, RC_EOF};
		for (int i = 0; i < 4; i++) begin
			listen();
			tehc_reader_inst.frame(2, 3'(i + 1), 1'b0, 1'b0);
			resp('{rc[i], LEN_ZERO});
		end
		listen();
		tehc_reader_inst.frame(5, RXE_NONE, 1'b0, 1'b0);
		resp('{RC_OVF, LEN_ZERO});
		listen();
		cmds('{CMD_ECHO});
		resp('{CMD_ECHO, RC_CANCEL, LEN_ZERO});
		`CHK(o_listening, 1'b0)
	endtask
	task automatic t_send();
		cmds('{CMD_SEND, 8'h03, 8'haa, 8'hbb, 8'h28});
		run <= 1'b1;
		resp('{RC_OK, LEN_ZERO});
		run <= 1'b0;
		`CHK(tehc_reader_inst.got.size(), 2)
		`CHK(tehc_reader_inst.got[0], 9'h0aa)
		`CHK(tehc_reader_inst.got[1], 9'h1bb)
		`CHK(o_lm_param, 8'h28)
		apb(1'b1, ADDR_CTRL, 32'h0);
		cmds('{CMD_SEND, 8'h01, 8'haa});
		resp('{RC_PROT, LEN_ZERO});
		cmds('{CMD_SEND, LEN_ZERO});
		resp('{RC_LEN, LEN_ZERO});
	endtask
	task automatic t_idle(input logic [7:0] src);
		logic [7:0] q[$];
		q = '{CMD_IDLE, LEN_IDLE, src, 8'h01, 8'h00, 8'h38, 8'h00, 8'h18, 8'h00};
		repeat (7) q.push_back(8'h00);
		cmds(q);
		`CHK(o_wait_for_event_state, 1'b1)
		`CHK({o_entry_resource_control, o_wake_resource_control, o_exit_resource_control}, 48'h010038001800)
		`CHK(o_wake_source_select, src)
		apb(1'b0, ADDR_CFG0, 32'h0);
		`CHK(rdv, 32'h38000100)
		apb(1'b0, ADDR_CFG1, 32'h0);
		`CHK(rdv, {16'h1800, 8'h00, src})
		apb(1'b0, ADDR_STAT, 32'h0);
		`CHK(rdv[3:0], 4'h4)
		apb(1'b1, ADDR_CMD, {24'h0, CMD_ECHO});
		`CHK(erv, 1'b1)
		// Disabled source first, then the enabled one
		i_field_det <= (src == WAKE_PIN);
		i_wake_b <= (src == WAKE_PIN);
		repeat (10) @(posedge i_core_clk);
		`CHK(o_wait_for_event_state, 1'b1)
		i_field_det <= 1'b1;
		i_wake_b <= 1'b0;
		repeat (10) @(posedge i_core_clk);
		i_field_det <= 1'b0;
		i_wake_b <= 1'b1;
		resp('{RC_OK, LEN_WAKE, src});
	endtask
	task automatic report_and_stop();
		if (bad_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge i_core_clk);
		bad_count++;
		report_and_stop();
	end
	initial begin
		{i_rst_b, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_field_det, run} = '0;
		i_wake_b = 1'b1;
		repeat (8) @(posedge i_core_clk);
		i_rst_b <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		t_regs();
		t_frame(1'b1, 1'b0);
		t_frame(1'b0, 1'b1);
		t_errs();
		apb(1'b1, ADDR_CTRL, 32'h3);
		t_send();
		t_idle(WAKE_PIN);
		t_idle(WAKE_FD);
		report_and_stop();
	end
endmodule
`default_nettype wire
